//--- include/smc_pkg.sv
// Constants for the standby mode controller: register map, fields, reset values.
// Assumes a 32-bit classic Wishbone slave port with byte addresses.
package smc_pkg;
   // Counter width for all stabilization waits
   localparam int unsigned CNT_W = 18;

   // Register byte addresses
   localparam logic [7:0] ADR_LOW_POWER = 8'h00;
   localparam logic [7:0] ADR_CLOCK_SEL = 8'h04;
   localparam logic [7:0] ADR_STATUS = 8'h08;
   localparam logic [7:0] ADR_EXT_INT = 8'h0C;

   // low_power_control_register fields
   localparam int unsigned LP_STOP_BIT = 0;
   localparam int unsigned LP_SLEEP_BIT = 1;
   localparam int unsigned LP_TBSEL_BIT = 2;
   localparam int unsigned LP_FLOAT_BIT = 3;
   localparam logic [7:0] LP_RESET = 8'h04;

   // clock_select_register fields
   localparam int unsigned CS_WS_LO = 0;
   localparam int unsigned CS_MODE_LO = 2;
   localparam int unsigned CS_MAIN_FLAG_BIT = 4;
   localparam int unsigned CS_SUB_FLAG_BIT = 5;
   localparam int unsigned CS_BUSY_BIT = 6;
   localparam logic [1:0] WS_RESET = 2'h3;

   // Status register fields
   localparam int unsigned ST_STATE_LO = 0;
   localparam int unsigned ST_PEND_BIT = 4;
   localparam int unsigned ST_KIND_LO = 5;

   // External interrupt configuration fields
   localparam int unsigned EX_EN_BIT = 0;
   localparam int unsigned EX_DET_LO = 1;
   localparam int unsigned EX_LVL_LO = 4;
   localparam int unsigned EX_FLAG_BIT = 8;
   localparam logic [2:0] EX_LVL_RESET = 3'h7;

   // Clock modes
   localparam logic [1:0] MODE_MAIN = 2'h0;
   localparam logic [1:0] MODE_PLL = 2'h1;
   localparam logic [1:0] MODE_SUB = 2'h2;

   // Requested standby kinds
   localparam logic [1:0] KIND_NONE = 2'h0;
   localparam logic [1:0] KIND_STOP = 2'h1;
   localparam logic [1:0] KIND_SLEEP = 2'h2;
   localparam logic [1:0] KIND_TBASE = 2'h3;

   // External detect conditions
   localparam logic [1:0] DET_LOW = 2'h0;
   localparam logic [1:0] DET_HIGH = 2'h1;
   localparam logic [1:0] DET_RISE = 2'h2;
   localparam logic [1:0] DET_FALL = 2'h3;

   // Requests must be strictly below this priority level to wake
   localparam logic [2:0] WAKE_LEVEL = 3'h7;

   // Fixed wait lengths in ticks
   localparam int unsigned PLL_WAIT_DEF = 16384;
   localparam int unsigned SUB_WAIT_DEF = 16384;

   typedef enum logic [2:0] {
      ST_RUN,
      ST_SWITCH,
      ST_SLEEP,
      ST_STOP,
      ST_WATCH,
      ST_TBASE,
      ST_WAKE
   } smc_state_type;
endpackage : smc_pkg

//--- include/smc_wait_if.sv
// Handshake between the sequencer and its stabilization wait counter.
// Assumes both ends run on mclk.
`timescale 1ns/1ps
interface smc_wait_if;
   logic start;
   logic [smc_pkg::CNT_W-1:0] len;
   logic tick;
   logic done;
   logic busy;
   modport ctrl (output start, output len, output tick, input done, input busy);
   modport timer (input start, input len, input tick, output done, output busy);
endinterface : smc_wait_if

//--- src/smc_wait_timer.sv
// Stabilization wait counter: counts len ticks after start, then pulses done.
// Assumes start is a one-cycle pulse and tick an enable pulse on mclk.
`timescale 1ns/1ps
module smc_wait_timer (
   input wire logic mclk,
   input wire logic rst,
   smc_wait_if.timer wt
);
   logic [smc_pkg::CNT_W-1:0] cnt_r;
   logic [smc_pkg::CNT_W-1:0] cnt_nxt;
   logic busy_r;
   logic busy_nxt;
   logic done_r;
   logic done_nxt;

   always_comb
   begin
      cnt_nxt = cnt_r;
      busy_nxt = busy_r;
      done_nxt = 1'b0;
      if (wt.start)
      begin
         cnt_nxt = wt.len;
         busy_nxt = 1'b1;
      end
      else if (busy_r && wt.tick)
      begin
         if (cnt_r <= smc_pkg::CNT_W'(1))
         begin
            cnt_nxt = '0;
            busy_nxt = 1'b0;
            done_nxt = 1'b1;
         end
         else
         begin
            cnt_nxt = cnt_r - smc_pkg::CNT_W'(1);
         end
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         cnt_r <= '0;
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
         busy_r <= busy_nxt;
         done_r <= done_nxt;
      end
   end

   assign wt.done = done_r;
   assign wt.busy = busy_r;
endmodule : smc_wait_timer

//--- src/smc_top.sv
// Standby mode controller: standby entry/exit, pin states, clock-mode switching.
// Assumes a classic Wishbone master on mclk and synchronous pin inputs.
// What this block does
// - Sleep, or deep standby without float, holds pin outputs; deep standby freezes inputs.
// - Deep standby with float set cuts input gates and turns output drivers off.
// - No standby entry while any interrupt request to the CPU is pending.
// - Held standby request proceeds once no interrupt request remains pending.
// - Interrupt request below level 7 cancels sleep, watch, timebase or stop.
// - Wake-up ignores whether the CPU currently accepts interrupts.
// - External wake input detects high level, low level, rising or falling edge.
// - Main oscillator stops in sub, watch, stop; restart waits wait-select time.
// - Subclock stops in every stop; sub-stop recovery waits a fixed SUB_WAIT_TICKS subclock ticks.
// - Main to PLL keeps CPU on main clock for fixed PLL wait.
// - Subclock mode stops main and PLL; switch to PLL waits wait-select time.
// - PLL stop recovery counts main and PLL waits together by wait-select.
// - Clock select register shows main and sub flags when switching completes.
// - Stop and sleep written together: stop wins.
`timescale 1ns/1ps
module smc_top #(
   parameter int unsigned NPIN = 8,
   parameter int unsigned WS_CYC0 = 1024,
   parameter int unsigned WS_CYC1 = 8192,
   parameter int unsigned WS_CYC2 = 32768,
   parameter int unsigned WS_CYC3 = 131072,
   parameter int unsigned PLL_WAIT_CYC = smc_pkg::PLL_WAIT_DEF,
   parameter int unsigned SUB_WAIT_TICKS = smc_pkg::SUB_WAIT_DEF,
   parameter int unsigned SUB_DIV = 4
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic per_irq_valid,
   input wire logic [2:0] per_irq_level,
   input wire logic ext_int_in,
   output logic ext_irq,
   input wire logic [NPIN-1:0] gp_out,
   input wire logic [NPIN-1:0] gp_oe,
   input wire logic [NPIN-1:0] pad_in,
   output logic [NPIN-1:0] pad_out,
   output logic [NPIN-1:0] pad_oe,
   output logic [NPIN-1:0] core_in,
   output logic cpu_clk_en,
   output logic [1:0] cpu_clk_src,
   output logic main_osc_en,
   output logic pll_en,
   output logic sub_osc_en
);
   localparam int unsigned CW = smc_pkg::CNT_W;
   localparam logic [CW-1:0] ONE = CW'(1);

   // Waits must fit the counter and be nonzero; divider 1 to 255; at least one pin
   if (WS_CYC3 >= (2 ** CW) || WS_CYC0 < 1 || PLL_WAIT_CYC < 1 || SUB_WAIT_TICKS < 1
       || PLL_WAIT_CYC >= (2 ** CW) || SUB_WAIT_TICKS >= (2 ** CW) || SUB_DIV < 1
       || SUB_DIV > 255 || NPIN < 1)
   begin : g_bad_param
      $error("smc_top: parameter out of range");
   end

   smc_wait_if wt ();

   smc_wait_timer u_timer (
      .mclk(mclk),
      .rst(rst),
      .wt(wt)
   );

   smc_pkg::smc_state_type state_r, state_nxt;
   logic ack_r, ack_nxt;
   logic [31:0] rdat_r, rdat_nxt;
   logic stop_bit_r, stop_bit_nxt;
   logic sleep_bit_r, sleep_bit_nxt;
   logic tbsel_r, tbsel_nxt;
   logic float_r, float_nxt;
   logic [1:0] ws_r, ws_nxt;
   logic [1:0] mode_req_r, mode_req_nxt;
   logic [1:0] cur_r, cur_nxt;
   logic [1:0] kind_r, kind_nxt;
   logic ex_en_r, ex_en_nxt;
   logic [1:0] ex_det_r, ex_det_nxt;
   logic [2:0] ex_lvl_r, ex_lvl_nxt;
   logic ex_flag_r, ex_flag_nxt;
   logic ex_prev_r, ex_prev_nxt;
   logic [7:0] subdiv_r, subdiv_nxt;
   logic tick_sub_r, tick_sub_nxt;
   logic main_on_r, main_on_nxt;
   logic pll_on_r, pll_on_nxt;
   logic sub_on_r, sub_on_nxt;
   logic [NPIN-1:0] hold_out_r, hold_out_nxt;
   logic [NPIN-1:0] hold_oe_r, hold_oe_nxt;
   logic [NPIN-1:0] hold_in_r, hold_in_nxt;
   logic [NPIN-1:0] pad_out_r, pad_out_nxt;
   logic [NPIN-1:0] pad_oe_r, pad_oe_nxt;
   logic [NPIN-1:0] core_in_r, core_in_nxt;

   logic req, wr, sub_tick, ex_hit, wake, pend_any, idle, deep, standby, fl_act;
   logic [31:0] rd_word;

   // Wait-select decode, shared by switching out of sub mode and main or PLL stop recovery
   function automatic logic [CW-1:0] ws_len(input logic [1:0] ws);
      case (ws)
         2'h0: ws_len = CW'(WS_CYC0);
         2'h1: ws_len = CW'(WS_CYC1);
         2'h2: ws_len = CW'(WS_CYC2);
         default: ws_len = CW'(WS_CYC3);
      endcase
   endfunction : ws_len

   always_comb
   begin
      req = wb_cyc_i & wb_stb_i;
      wr = req & ack_r & wb_we_i & wb_sel_i[0];
      sub_tick = sub_on_r && (subdiv_r == 8'h00);
      idle = (state_r == smc_pkg::ST_RUN) && !wt.busy && (kind_r == smc_pkg::KIND_NONE);
      deep = (state_r == smc_pkg::ST_STOP) || (state_r == smc_pkg::ST_WATCH)
             || (state_r == smc_pkg::ST_TBASE) || (state_r == smc_pkg::ST_WAKE);
      standby = deep || (state_r == smc_pkg::ST_SLEEP);
      fl_act = deep && float_r;
      case (ex_det_r)
         smc_pkg::DET_LOW: ex_hit = !ext_int_in;
         smc_pkg::DET_HIGH: ex_hit = ext_int_in;
         smc_pkg::DET_RISE: ex_hit = ext_int_in && !ex_prev_r;
         default: ex_hit = !ext_int_in && ex_prev_r;
      endcase
      ex_hit = ex_hit && ex_en_r;
      // level gate only, no CPU enable term
      wake = (per_irq_valid && (per_irq_level < smc_pkg::WAKE_LEVEL))
             || (ex_flag_r && (ex_lvl_r < smc_pkg::WAKE_LEVEL));
      pend_any = per_irq_valid || ex_flag_r;
      rd_word = 32'h0000_0000;
      case (wb_adr_i)
         smc_pkg::ADR_LOW_POWER:
         begin
            rd_word[smc_pkg::LP_STOP_BIT] = stop_bit_r;
            rd_word[smc_pkg::LP_SLEEP_BIT] = sleep_bit_r;
            rd_word[smc_pkg::LP_TBSEL_BIT] = tbsel_r;
            rd_word[smc_pkg::LP_FLOAT_BIT] = float_r;
         end
         smc_pkg::ADR_CLOCK_SEL:
         begin
            rd_word[smc_pkg::CS_WS_LO +: 2] = ws_r;
            rd_word[smc_pkg::CS_MODE_LO +: 2] = mode_req_r;
            rd_word[smc_pkg::CS_MAIN_FLAG_BIT] = (cur_r == smc_pkg::MODE_MAIN);
            rd_word[smc_pkg::CS_SUB_FLAG_BIT] = (cur_r == smc_pkg::MODE_SUB);
            rd_word[smc_pkg::CS_BUSY_BIT] = (cur_r != mode_req_r);
         end
         smc_pkg::ADR_STATUS:
         begin
            rd_word[smc_pkg::ST_STATE_LO +: 3] = 3'(state_r);
            rd_word[smc_pkg::ST_PEND_BIT] = pend_any;
            rd_word[smc_pkg::ST_KIND_LO +: 2] = kind_r;
         end
         smc_pkg::ADR_EXT_INT:
         begin
            rd_word[smc_pkg::EX_EN_BIT] = ex_en_r;
            rd_word[smc_pkg::EX_DET_LO +: 2] = ex_det_r;
            rd_word[smc_pkg::EX_LVL_LO +: 3] = ex_lvl_r;
            rd_word[smc_pkg::EX_FLAG_BIT] = ex_flag_r;
         end
         default: rd_word = 32'h0000_0000;
      endcase
   end

   always_comb
   begin
      state_nxt = state_r;
      ack_nxt = req & ~ack_r;
      rdat_nxt = (req & ~ack_r) ? rd_word : rdat_r;
      stop_bit_nxt = stop_bit_r;
      sleep_bit_nxt = sleep_bit_r;
      tbsel_nxt = tbsel_r;
      float_nxt = float_r;
      ws_nxt = ws_r;
      mode_req_nxt = mode_req_r;
      cur_nxt = cur_r;
      kind_nxt = kind_r;
      ex_en_nxt = ex_en_r;
      ex_det_nxt = ex_det_r;
      ex_lvl_nxt = ex_lvl_r;
      ex_flag_nxt = ex_flag_r;
      ex_prev_nxt = ext_int_in;
      subdiv_nxt = (subdiv_r == 8'(SUB_DIV - 1)) ? 8'h00 : subdiv_r + 8'h01;
      tick_sub_nxt = tick_sub_r;
      main_on_nxt = main_on_r;
      pll_on_nxt = pll_on_r;
      sub_on_nxt = sub_on_r;
      hold_out_nxt = hold_out_r;
      hold_oe_nxt = hold_oe_r;
      hold_in_nxt = hold_in_r;
      wt.start = 1'b0;
      wt.len = ONE;
      wt.tick = tick_sub_r ? sub_tick : 1'b1;

      // Flag clear by writing one; a new detection in the same cycle wins
      if (req && ack_r && wb_we_i && wb_sel_i[1] && (wb_adr_i == smc_pkg::ADR_EXT_INT)
          && wb_dat_i[smc_pkg::EX_FLAG_BIT])
         ex_flag_nxt = 1'b0;
      if (ex_hit)
         ex_flag_nxt = 1'b1;

      if (wr && (wb_adr_i == smc_pkg::ADR_EXT_INT))
      begin
         ex_en_nxt = wb_dat_i[smc_pkg::EX_EN_BIT];
         ex_det_nxt = wb_dat_i[smc_pkg::EX_DET_LO +: 2];
         ex_lvl_nxt = wb_dat_i[smc_pkg::EX_LVL_LO +: 3];
      end
      if (wr && (wb_adr_i == smc_pkg::ADR_CLOCK_SEL))
      begin
         ws_nxt = wb_dat_i[smc_pkg::CS_WS_LO +: 2];
         // mode change refused while busy or a standby is held
         if (idle && (cur_r == mode_req_r) && (wb_dat_i[smc_pkg::CS_MODE_LO +: 2] != 2'h3))
            mode_req_nxt = wb_dat_i[smc_pkg::CS_MODE_LO +: 2];
      end
      // standby writes ignored until the switch completes
      if (wr && (wb_adr_i == smc_pkg::ADR_LOW_POWER) && idle && (cur_r == mode_req_r))
      begin
         stop_bit_nxt = wb_dat_i[smc_pkg::LP_STOP_BIT];
         sleep_bit_nxt = wb_dat_i[smc_pkg::LP_SLEEP_BIT];
         tbsel_nxt = wb_dat_i[smc_pkg::LP_TBSEL_BIT];
         float_nxt = wb_dat_i[smc_pkg::LP_FLOAT_BIT];
         if (wb_dat_i[smc_pkg::LP_STOP_BIT])
            kind_nxt = smc_pkg::KIND_STOP;
         else if (wb_dat_i[smc_pkg::LP_SLEEP_BIT])
            kind_nxt = smc_pkg::KIND_SLEEP;
         else if (!wb_dat_i[smc_pkg::LP_TBSEL_BIT])
            kind_nxt = smc_pkg::KIND_TBASE;
      end

      case (state_r)
         smc_pkg::ST_RUN:
         begin
            // entry held off while requests pend
            if ((kind_r != smc_pkg::KIND_NONE) && !pend_any)
            begin
               // snapshot of pin state at entry
               hold_out_nxt = gp_out;
               hold_oe_nxt = gp_oe;
               hold_in_nxt = pad_in;
               kind_nxt = smc_pkg::KIND_NONE;
               if (kind_r == smc_pkg::KIND_STOP)
               begin
                  state_nxt = smc_pkg::ST_STOP;
                  main_on_nxt = 1'b0;
                  pll_on_nxt = 1'b0;
                  sub_on_nxt = 1'b0;
               end
               else if (kind_r == smc_pkg::KIND_SLEEP)
                  state_nxt = smc_pkg::ST_SLEEP;
               else if (cur_r == smc_pkg::MODE_SUB)
                  state_nxt = smc_pkg::ST_WATCH;
               else
                  state_nxt = smc_pkg::ST_TBASE;
            end
            else if (mode_req_r != cur_r)
            begin
               if ((cur_r == smc_pkg::MODE_MAIN) && (mode_req_r == smc_pkg::MODE_PLL))
               begin
                  // CPU stays on main during PLL wait
                  pll_on_nxt = 1'b1;
                  tick_sub_nxt = 1'b0;
                  wt.start = 1'b1;
                  wt.len = CW'(PLL_WAIT_CYC);
                  state_nxt = smc_pkg::ST_SWITCH;
               end
               else if (cur_r == smc_pkg::MODE_SUB)
               begin
                  main_on_nxt = 1'b1;
                  pll_on_nxt = (mode_req_r == smc_pkg::MODE_PLL);
                  tick_sub_nxt = 1'b0;
                  wt.start = 1'b1;
                  wt.len = ws_len(ws_r);
                  state_nxt = smc_pkg::ST_SWITCH;
               end
               else
               begin
                  cur_nxt = mode_req_r;
                  pll_on_nxt = 1'b0;
                  // subclock mode stops main and PLL
                  if (mode_req_r == smc_pkg::MODE_SUB)
                     main_on_nxt = 1'b0;
               end
            end
         end
         smc_pkg::ST_SWITCH:
            if (wt.done)
            begin
               cur_nxt = mode_req_r;
               state_nxt = smc_pkg::ST_RUN;
            end
         smc_pkg::ST_SLEEP, smc_pkg::ST_WATCH, smc_pkg::ST_TBASE:
            if (wake)
            begin
               tbsel_nxt = 1'b1;
               sleep_bit_nxt = 1'b0;
               state_nxt = smc_pkg::ST_RUN;
            end
         smc_pkg::ST_STOP:
            if (wake)
            begin
               wt.start = 1'b1;
               state_nxt = smc_pkg::ST_WAKE;
               if (cur_r == smc_pkg::MODE_SUB)
               begin
                  // fixed subclock wait on sub ticks
                  sub_on_nxt = 1'b1;
                  tick_sub_nxt = 1'b1;
                  wt.len = CW'(SUB_WAIT_TICKS);
               end
               else
               begin
                  // main and PLL waits counted as one
                  main_on_nxt = 1'b1;
                  sub_on_nxt = 1'b1;
                  pll_on_nxt = (cur_r == smc_pkg::MODE_PLL);
                  tick_sub_nxt = 1'b0;
                  wt.len = ws_len(ws_r);
               end
            end
         smc_pkg::ST_WAKE:
            if (wt.done)
            begin
               stop_bit_nxt = 1'b0;
               tick_sub_nxt = 1'b0;
               state_nxt = smc_pkg::ST_RUN;
            end
         default: state_nxt = smc_pkg::ST_RUN;
      endcase

      // pin enables from state and float select
      pad_out_nxt = standby ? hold_out_r : gp_out;
      pad_oe_nxt = fl_act ? '0 : (standby ? hold_oe_r : gp_oe);
      core_in_nxt = fl_act ? '0 : (deep ? hold_in_r : pad_in);
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         state_r <= smc_pkg::ST_RUN;
         ack_r <= 1'b0;
         rdat_r <= 32'h0000_0000;
         stop_bit_r <= smc_pkg::LP_RESET[smc_pkg::LP_STOP_BIT];
         sleep_bit_r <= smc_pkg::LP_RESET[smc_pkg::LP_SLEEP_BIT];
         tbsel_r <= smc_pkg::LP_RESET[smc_pkg::LP_TBSEL_BIT];
         float_r <= smc_pkg::LP_RESET[smc_pkg::LP_FLOAT_BIT];
         ws_r <= smc_pkg::WS_RESET;
         mode_req_r <= smc_pkg::MODE_MAIN;
         cur_r <= smc_pkg::MODE_MAIN;
         kind_r <= smc_pkg::KIND_NONE;
         ex_en_r <= 1'b0;
         ex_det_r <= smc_pkg::DET_LOW;
         ex_lvl_r <= smc_pkg::EX_LVL_RESET;
         ex_flag_r <= 1'b0;
         ex_prev_r <= 1'b0;
         subdiv_r <= 8'h00;
         tick_sub_r <= 1'b0;
         main_on_r <= 1'b1;
         pll_on_r <= 1'b0;
         sub_on_r <= 1'b1;
         hold_out_r <= '0;
         hold_oe_r <= '0;
         hold_in_r <= '0;
         pad_out_r <= '0;
         pad_oe_r <= '0;
         core_in_r <= '0;
      end
      else
      begin
         state_r <= state_nxt;
         ack_r <= ack_nxt;
         rdat_r <= rdat_nxt;
         stop_bit_r <= stop_bit_nxt;
         sleep_bit_r <= sleep_bit_nxt;
         tbsel_r <= tbsel_nxt;
         float_r <= float_nxt;
         ws_r <= ws_nxt;
         mode_req_r <= mode_req_nxt;
         cur_r <= cur_nxt;
         kind_r <= kind_nxt;
         ex_en_r <= ex_en_nxt;
         ex_det_r <= ex_det_nxt;
         ex_lvl_r <= ex_lvl_nxt;
         ex_flag_r <= ex_flag_nxt;
         ex_prev_r <= ex_prev_nxt;
         subdiv_r <= subdiv_nxt;
         tick_sub_r <= tick_sub_nxt;
         main_on_r <= main_on_nxt;
         pll_on_r <= pll_on_nxt;
         sub_on_r <= sub_on_nxt;
         hold_out_r <= hold_out_nxt;
         hold_oe_r <= hold_oe_nxt;
         hold_in_r <= hold_in_nxt;
         pad_out_r <= pad_out_nxt;
         pad_oe_r <= pad_oe_nxt;
         core_in_r <= core_in_nxt;
      end
   end

   // CPU clock gated in every standby and recovery state
   assign cpu_clk_en = (state_r == smc_pkg::ST_RUN) || (state_r == smc_pkg::ST_SWITCH);
   assign cpu_clk_src = cur_r;
   assign main_osc_en = main_on_r;
   assign pll_en = pll_on_r;
   assign sub_osc_en = sub_on_r;
   assign ext_irq = ex_flag_r;
   assign wb_ack_o = ack_r;
   assign wb_dat_o = rdat_r;
   assign pad_out = pad_out_r;
   assign pad_oe = pad_oe_r;
   assign core_in = core_in_r;
endmodule : smc_top

//--- verif/smc_props.sv
// Port checker for the standby controller.
// Assumes the short wait parameters that the bench sets.
`timescale 1ns/1ps
module smc_props #(
   parameter int unsigned NPIN = 8
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic per_irq_valid,
   input wire logic [2:0] per_irq_level,
   input wire logic [NPIN-1:0] pad_out,
   input wire logic [NPIN-1:0] pad_oe,
   input wire logic cpu_clk_en,
   input wire logic [1:0] cpu_clk_src,
   input wire logic main_osc_en,
   input wire logic pll_en
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);
   sequence s_on_main;
      (cpu_clk_src == smc_pkg::MODE_MAIN) [*3];
   endsequence
   property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
   property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
   property p_block; $fell(cpu_clk_en) |-> !$past(per_irq_valid); endproperty
   property p_wake;
      !cpu_clk_en && per_irq_valid && per_irq_level < 3'h7 |-> ##[1:20] cpu_clk_en;
   endproperty
   // Two settled cycles first: pads lag the state by one register
   property p_hold;
      !cpu_clk_en && !$past(cpu_clk_en) && !$past(cpu_clk_en, 2)
         |-> $stable(pad_out) && $stable(pad_oe);
   endproperty
   property p_mwait; $rose(main_osc_en) && !cpu_clk_en |-> !cpu_clk_en [*4]; endproperty
   property p_pll;
      $rose(pll_en) && cpu_clk_src == smc_pkg::MODE_MAIN
         |-> s_on_main ##[1:8] cpu_clk_src == smc_pkg::MODE_PLL;
   endproperty
   property p_sub;
      $rose(cpu_clk_src == smc_pkg::MODE_SUB) |-> ##[0:1] !main_osc_en && !pll_en;
   endproperty
   a_ack: assert property (p_ack) else $error("ack missing");
   a_pulse: assert property (p_pulse) else $error("ack too long");
   a_block: assert property (p_block) else $error("entry while pending");
   a_wake: assert property (p_wake) else $error("no wake");
   a_hold: assert property (p_hold) else $error("pins moved");
   a_mwait: assert property (p_mwait) else $error("main wait short");
   a_pll: assert property (p_pll) else $error("pll switch timing");
   a_sub: assert property (p_sub) else $error("osc on in sub");
endmodule : smc_props
bind smc_top smc_props #(.NPIN(NPIN)) smc_props_i (.mclk(mclk), .rst(rst),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
   .per_irq_valid(per_irq_valid), .per_irq_level(per_irq_level), .pad_out(pad_out),
   .pad_oe(pad_oe), .cpu_clk_en(cpu_clk_en), .cpu_clk_src(cpu_clk_src),
   .main_osc_en(main_osc_en), .pll_en(pll_en));

//--- verif/smc_irq_model.sv
// Interrupt sources and external wake pin at the far side.
// Assumes callers use it from the bench's own process.
`timescale 1ns/1ps
module smc_irq_model (
   input wire logic mclk,
   output logic irq_v,
   output logic [2:0] irq_l,
   output logic pin
);
   initial {irq_v, irq_l, pin} = 5'h0E;
   // request, level and pin driven at the next mclk edge and held until the next call
   task automatic drive(input logic v, input logic [2:0] l, input logic p);
      @(posedge mclk);
      irq_v <= v;
      irq_l <= l;
      pin <= p;
   endtask : drive
endmodule : smc_irq_model

//--- verif/testbench.sv
// Self-checking bench for the standby controller top.
// Assumes short wait parameters; the bench is the bus master.
`timescale 1ns/1ps
module testbench;
   localparam logic [7:0] lp_a = smc_pkg::ADR_LOW_POWER;
   localparam logic [7:0] cs_a = smc_pkg::ADR_CLOCK_SEL;
   localparam logic [7:0] st_a = smc_pkg::ADR_STATUS;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic cyc = 1'b0;
   logic we = 1'b0;
   logic act;
   logic [7:0] adr = 8'h00;
   logic [31:0] wd = 32'h0;
   logic [7:0] gpo = 8'h00;
   logic [7:0] gpe = 8'hFF;
   logic [7:0] pdi = 8'h00;
   logic [31:0] rdat, q;
   logic [31:0] rnd = 32'h5EE0C95D;
   logic ack, irq_v, pin, ext_irq, clk_en, mosc, pll, sosc;
   logic [2:0] irq_l;
   logic [1:0] src;
   logic [7:0] pout, poe, cin, eo, ee;
   int err_total = 0;
   int n_checks = 0;
   int cyc_cnt = 0;
   always #4 mclk = ~mclk;
   smc_irq_model smc_irq_model_i (.mclk(mclk), .irq_v(irq_v), .irq_l(irq_l), .pin(pin));
   smc_top #(.WS_CYC3(6), .PLL_WAIT_CYC(4),
      .SUB_WAIT_TICKS(3), .SUB_DIV(2)) smc_top_i (.mclk(mclk), .rst(rst), .wb_cyc_i(cyc),
      .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wd),
      .wb_dat_o(rdat), .wb_ack_o(ack), .per_irq_valid(irq_v), .per_irq_level(irq_l),
      .ext_int_in(pin), .ext_irq(ext_irq), .gp_out(gpo), .gp_oe(gpe), .pad_in(pdi),
      .pad_out(pout), .pad_oe(poe), .core_in(cin), .cpu_clk_en(clk_en),
      .cpu_clk_src(src), .main_osc_en(mosc), .pll_en(pll), .sub_osc_en(sosc));
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr
   function automatic logic [31:0] cs_exp(input logic [1:0] m);
      return {26'h0, m == smc_pkg::MODE_SUB, m == smc_pkg::MODE_MAIN, m, 2'h3};
   endfunction : cs_exp
   task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("wrong value %s exp %h seen %h", s, exp, seen);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wd <= d;
      do @(posedge mclk); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
   endtask : bus
   task automatic rd(input logic [7:0] a, input logic [31:0] m, e, input string s);
      bus(1'b0, a, 32'h0);
      chk(s, q & m, e);
   endtask : rd
   task automatic run_back();
      repeat (40) if (clk_en !== 1'b1) @(posedge mclk);
      chk("cpu clock", {31'h0, clk_en}, 32'h1);
   endtask : run_back
   // Requests made while busy are dropped, so software polls first
   task automatic poll();
      q = 32'h40;
      repeat (10) if (q[6] !== 1'b0) bus(1'b0, cs_a, 32'h0);
   endtask : poll
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : tally_and_finish
   always @(posedge mclk)
   begin
      cyc_cnt++;
      if (cyc_cnt == 6000)
      begin
         err_total++;
         tally_and_finish();
      end
   end
   initial
   begin
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      rd(lp_a, 32'hFF, 32'h04, "lp reset");
      rd(cs_a, 32'h7F, cs_exp(smc_pkg::MODE_MAIN), "cs reset");
      rd(8'h10, 32'hFFFFFFFF, 32'h0, "hole");
      $display("test reset done");
      smc_irq_model_i.drive(1'b1, 3'h2, 1'b0);
      bus(1'b1, lp_a, 32'h06);
      rd(st_a, 32'h77, 32'h50, "held sleep");
      smc_irq_model_i.drive(1'b0, 3'h2, 1'b0);
      rd(st_a, 32'h07, 32'h2, "sleep");
      smc_irq_model_i.drive(1'b1, 3'h7, 1'b0);
      rd(st_a, 32'h07, 32'h2, "level 7");
      rnd = lfsr(rnd);
      smc_irq_model_i.drive(1'b1, 3'(rnd % 7), 1'b0);
      run_back();
      smc_irq_model_i.drive(1'b0, 3'h7, 1'b0);
      $display("test sleep done");
      for (int d = 0; d < 4; d++)
      begin
         act = d == 1 || d == 2;
         smc_irq_model_i.drive(1'b0, 3'h7, !act);
         repeat (2) bus(1'b1, smc_pkg::ADR_EXT_INT, 32'h100);
         bus(1'b1, smc_pkg::ADR_EXT_INT, 32'h101 | 32'(d << 1));
         bus(1'b1, lp_a, 32'h0F);
         rd(st_a, 32'h07, 32'h3, "stop");
         chk("float", {24'h0, poe}, 32'h0);
         chk("main osc", {31'h0, mosc}, 32'h0);
         smc_irq_model_i.drive(1'b0, 3'h7, act);
         run_back();
         chk("ext flag", {31'h0, ext_irq}, 32'h1);
      end
      bus(1'b1, smc_pkg::ADR_EXT_INT, 32'h100);
      $display("test stop done");
      rnd = lfsr(rnd);
      {gpo, gpe, pdi} <= rnd[23:0];
      bus(1'b1, lp_a, 32'h00);
      repeat (3) @(posedge mclk);
      eo = gpo;
      ee = gpe;
      {gpo, pdi} <= ~{gpo, pdi};
      rd(st_a, 32'h07, 32'h5, "timebase");
      chk("held out", {24'h0, pout}, {24'h0, eo});
      chk("held oe", {24'h0, poe}, {24'h0, ee});
      chk("held in", {24'h0, cin}, {24'h0, ~pdi});
      smc_irq_model_i.drive(1'b1, 3'h0, 1'b0);
      run_back();
      smc_irq_model_i.drive(1'b0, 3'h7, 1'b0);
      $display("test timebase done");
      for (int m = 1; m < 3; m++)
      begin
         bus(1'b1, cs_a, 32'h3 | 32'(m << 2));
         poll();
         rd(cs_a, 32'h7F, cs_exp(2'(m)), "mode");
         bus(1'b1, lp_a, 32'h05);
         rd(st_a, 32'h07, 32'h3, "clock stop");
         chk("pll off", {31'h0, pll}, 32'h0);
         smc_irq_model_i.drive(1'b1, 3'h1, 1'b0);
         run_back();
         smc_irq_model_i.drive(1'b0, 3'h7, 1'b0);
      end
      bus(1'b1, cs_a, 32'h07);
      bus(1'b1, cs_a, 32'h03);
      poll();
      rd(cs_a, 32'h7F, cs_exp(smc_pkg::MODE_PLL), "sub to pll");
      $display("test clock done");
      tally_and_finish();
   end
endmodule : testbench
